// file: src/acrs_pkg.sv
// shared constants for the converter control word and read-select logic
package acrs_pkg;
    localparam int CTRL_W = 14;
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam int BIT_LAUNCH = 0;
    localparam int BIT_CHOICE_LO = 1;
    localparam int BIT_CHOICE_HI = 2;
    localparam int BIT_KIND = 3;
    localparam int BIT_SOFT_CONV = 4;
    localparam int BIT_RANGE = 5;
    localparam int BIT_RDSEL_LO = 6;
    localparam int BIT_RDSEL_HI = 7;
    localparam int BIT_PWR_LO = 8;
    localparam int BIT_PWR_HI = 9;
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_TEST = 2'h1;
    localparam logic [1:0] TGT_CAL = 2'h2;
    localparam logic [1:0] TGT_CTRL = 2'h3;
    localparam logic [1:0] RD_DATA = 2'h0;
    localparam logic [1:0] RD_TEST = 2'h1;
    localparam logic [1:0] RD_CAL = 2'h2;
    localparam logic [1:0] RD_STATUS = 2'h3;
    localparam logic [1:0] STATUS_ONES = 2'h3;
    // calibration steps, in the order a sequence runs them
    localparam logic [2:0] STEP_DAC = 3'h4;
    localparam logic [2:0] STEP_GAIN = 3'h2;
    localparam logic [2:0] STEP_OFFS = 3'h1;
    typedef enum logic [2:0] {
        ACRS_CAL_FULL_INT, ACRS_CAL_GO_INT, ACRS_CAL_OFFS_INT, ACRS_CAL_GAIN_INT,
        ACRS_CAL_FULL_SYS, ACRS_CAL_GO_SYS, ACRS_CAL_OFFS_SYS, ACRS_CAL_GAIN_SYS
    } acrs_cal_e;
endpackage

// file: src/acrs_byte_pair.sv
// assembles two host byte writes into one 16-bit word
`timescale 1ns/1ps
`default_nettype none
module acrs_byte_pair (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic byteWr, // one-cycle byte write strobe
    input wire logic [7:0] byteIn, // byte from the data pins
    output logic wordValid, // pulse: full word assembled
    output logic [15:0] wordOut // assembled word
);
    logic haveLow_q;
    logic [7:0] lowByte_q;

    // low byte first, high byte second
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            haveLow_q <= 1'b0;
            lowByte_q <= 8'h00;
        end else if (byteWr) begin
            haveLow_q <= !haveLow_q;
            if (!haveLow_q) begin
                lowByte_q <= byteIn;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wordValid <= 1'b0;
            wordOut <= 16'h0000;
        end else begin
            wordValid <= byteWr && haveLow_q;
            if (byteWr && haveLow_q) begin
                wordOut <= {byteIn, lowByte_q};
            end
        end
    end
endmodule
`default_nettype wire

// file: src/acrs_control_read_select.sv
// converter control word, write decode and read-select multiplexer
`timescale 1ns/1ps
`default_nettype none
module acrs_control_read_select #(
    parameter int DATA_W = 12 // conversion result width
) (
    input wire logic core_clk, // core clock
    input wire logic resetn, // async reset, active low
    input wire logic byteWr, // one-cycle byte write strobe
    input wire logic [7:0] byteIn, // write byte on low data pins
    input wire logic sleepPin, // sleep pin, asynchronous
    input wire logic [DATA_W-1:0] convResult, // conversion result
    input wire logic convDone, // pulse: conversion ended
    input wire logic calDone, // pulse: calibration ended
    input wire logic [15:0] testRdData, // test register contents
    input wire logic [15:0] calRdData, // addressed coefficient word
    output logic [15:0] readData, // word presented on reads
    output logic [13:0] testWrData, // test register write data
    output logic testWrEn, // pulse: test register write
    output logic [13:0] calWrData, // coefficient write data
    output logic calWrEn, // pulse: coefficient write
    output logic [1:0] calAddr, // coefficient register select
    output logic convStart, // pulse: start one conversion
    output logic calStart, // pulse: start calibration
    output logic [2:0] calSteps, // dac/gain/offset step mask
    output logic bipolarRange, // 1: bipolar, twos complement
    output logic [2:0] powerMode, // {sleep, power field}
    output logic busy // conversion or calibration running
);
    // ==========================================================
    // word assembly and write decode
    logic wordValid;
    logic [15:0] word;
    logic [13:0] ctrl_q;
    logic [13:0] ctrl_d;
    logic convBusy_q;
    logic calBusy_q;
    logic sleepMeta_q;
    logic sleepSync_q;

    acrs_byte_pair i_acrs_byte_pair (
        .core_clk(core_clk),
        .resetn(resetn),
        .byteWr(byteWr),
        .byteIn(byteIn),
        .wordValid(wordValid),
        .wordOut(word)
    );

    // ==========================================================
    // write target decode
    // one decode shared by every destination, so a word never reaches two targets
    function automatic logic hits_target(input logic valid, input logic [1:0] tgt,
        input logic [1:0] want);
        return valid && (tgt == want);
    endfunction

    logic [1:0] target;
    logic ctrlWr;
    logic testWr;
    logic calWr;

    assign target = word[15:14];
    assign ctrlWr = hits_target(wordValid, target, acrs_pkg::TGT_CTRL);
    assign testWr = hits_target(wordValid, target, acrs_pkg::TGT_TEST);
    assign calWr = hits_target(wordValid, target, acrs_pkg::TGT_CAL);

    // ==========================================================
    // calibration step decode
    function automatic logic [2:0] cal_steps(input logic [2:0] code);
        logic [2:0] s;
        s = acrs_pkg::STEP_GAIN;
        case (acrs_pkg::acrs_cal_e'(code))
            acrs_pkg::ACRS_CAL_FULL_INT, acrs_pkg::ACRS_CAL_FULL_SYS: begin
                s = acrs_pkg::STEP_DAC | acrs_pkg::STEP_GAIN | acrs_pkg::STEP_OFFS;
            end
            acrs_pkg::ACRS_CAL_GO_INT, acrs_pkg::ACRS_CAL_GO_SYS: begin
                s = acrs_pkg::STEP_GAIN | acrs_pkg::STEP_OFFS;
            end
            acrs_pkg::ACRS_CAL_OFFS_INT, acrs_pkg::ACRS_CAL_OFFS_SYS: begin
                s = acrs_pkg::STEP_OFFS;
            end
            acrs_pkg::ACRS_CAL_GAIN_INT, acrs_pkg::ACRS_CAL_GAIN_SYS: begin
                s = acrs_pkg::STEP_GAIN;
            end
            default: begin
                s = acrs_pkg::STEP_GAIN;
            end
        endcase
        return s;
    endfunction

    // ==========================================================
    // control word
    // start bits self-clear on the done pulse; a fresh write wins over the done
    always_comb begin
        ctrl_d = ctrl_q;
        if (convDone) begin
            ctrl_d[acrs_pkg::BIT_SOFT_CONV] = 1'b0;
        end
        if (calDone) begin
            ctrl_d[acrs_pkg::BIT_LAUNCH] = 1'b0;
        end
        if (ctrlWr) begin
            // bits 13:10 stored as written; host keeps them zero
            ctrl_d = word[13:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= acrs_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==========================================================
    // start pulses and busy tracking
    // a start written while already running is ignored, so one write gives one run
    logic convKick;
    logic calKick;
    assign convKick = ctrlWr && word[acrs_pkg::BIT_SOFT_CONV] && !convBusy_q && !calBusy_q;
    assign calKick = ctrlWr && word[acrs_pkg::BIT_LAUNCH] && !calBusy_q && !convBusy_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            convStart <= 1'b0;
        end else begin
            convStart <= convKick;
        end
    end

    // busy holds from the start pulse until the matching done pulse
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            convBusy_q <= 1'b0;
        end else if (convKick) begin
            convBusy_q <= 1'b1;
        end else if (convDone) begin
            convBusy_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calStart <= 1'b0;
        end else begin
            calStart <= calKick;
        end
    end

    // mask frozen at launch; later writes to bits 2:1 only move the coefficient address
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calSteps <= 3'h0;
        end else if (calKick) begin
            calSteps <= cal_steps(word[acrs_pkg::BIT_KIND:acrs_pkg::BIT_CHOICE_LO]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calBusy_q <= 1'b0;
        end else if (calKick) begin
            calBusy_q <= 1'b1;
        end else if (calDone) begin
            calBusy_q <= 1'b0;
        end
    end

    // a stray done pulse with nothing running is harmless: the flag is already clear
    assign busy = convBusy_q || calBusy_q;

    // ==========================================================
    // mode outputs
    // the sleep pin may move at any time, so two flops stand before any use
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleepMeta_q <= 1'b0;
        end else begin
            sleepMeta_q <= sleepPin;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sleepSync_q <= 1'b0;
        end else begin
            sleepSync_q <= sleepMeta_q;
        end
    end

    // fed from ctrl_d so the modes turn over on the same edge as the register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            powerMode <= 3'h0;
        end else begin
            powerMode <= {sleepSync_q, ctrl_d[acrs_pkg::BIT_PWR_HI:acrs_pkg::BIT_PWR_LO]};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bipolarRange <= 1'b0;
        end else begin
            bipolarRange <= ctrl_d[acrs_pkg::BIT_RANGE];
        end
    end

    // coefficient address only meaningful while no calibration launched
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calAddr <= 2'h0;
        end else begin
            calAddr <= ctrl_d[acrs_pkg::BIT_CHOICE_HI:acrs_pkg::BIT_CHOICE_LO];
        end
    end

    // ==========================================================
    // test and calibration register writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            testWrEn <= 1'b0;
        end else begin
            testWrEn <= testWr;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            testWrData <= 14'h0000;
        end else if (testWr) begin
            testWrData <= word[13:0];
        end
    end

    // while a calibration is launched the select bits name its type, not a register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calWrEn <= 1'b0;
        end else begin
            calWrEn <= calWr && !ctrl_q[acrs_pkg::BIT_LAUNCH];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            calWrData <= 14'h0000;
        end else if (calWr) begin
            calWrData <= word[13:0];
        end
    end

    // ==========================================================
    // read multiplexer
    logic [15:0] statusWord;
    always_comb begin
        statusWord = 16'h0000;
        statusWord[acrs_pkg::BIT_PWR_HI:acrs_pkg::BIT_PWR_LO] =
            ctrl_q[acrs_pkg::BIT_PWR_HI:acrs_pkg::BIT_PWR_LO];
        statusWord[acrs_pkg::BIT_RDSEL_HI:acrs_pkg::BIT_RDSEL_LO] = acrs_pkg::STATUS_ONES;
        statusWord[acrs_pkg::BIT_RANGE] = ctrl_q[acrs_pkg::BIT_RANGE];
        statusWord[acrs_pkg::BIT_SOFT_CONV] = convBusy_q || calBusy_q;
        statusWord[acrs_pkg::BIT_KIND:acrs_pkg::BIT_CHOICE_LO] =
            ctrl_q[acrs_pkg::BIT_KIND:acrs_pkg::BIT_CHOICE_LO];
        statusWord[acrs_pkg::BIT_LAUNCH] = calBusy_q;
    end

    // taken from the stored word, so it persists across any number of reads
    logic [1:0] readSel;
    assign readSel = ctrl_q[acrs_pkg::BIT_RDSEL_HI:acrs_pkg::BIT_RDSEL_LO];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            readData <= 16'h0000;
        end else begin
            case (readSel)
                acrs_pkg::RD_DATA: begin
                    readData <= {{(16-DATA_W){1'b0}}, convResult};
                end
                acrs_pkg::RD_TEST: begin
                    readData <= testRdData;
                end
                acrs_pkg::RD_CAL: begin
                    readData <= calRdData;
                end
                acrs_pkg::RD_STATUS: begin
                    readData <= statusWord;
                end
                default: begin
                    readData <= 16'h0000;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: sim/acrs_control_read_select_asserts.sv
// port checker for the control word and read-select block
`timescale 1ns/1ps
`default_nettype none
module acrs_control_read_select_asserts (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic byteWr, // byte strobe
    input wire logic [15:0] readData, // read word
    input wire logic testWrEn, // test write pulse
    input wire logic calWrEn, // coefficient write pulse
    input wire logic [1:0] calAddr, // coefficient select
    input wire logic convStart, // conversion start
    input wire logic calStart, // calibration start
    input wire logic [2:0] calSteps, // step mask
    input wire logic bipolarRange, // range
    input wire logic [2:0] powerMode, // power mode
    input wire logic busy // busy
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // ==========
    // assertions
    a_reset_state: assert property ($rose(resetn) |-> readData == 16'h0000 && !busy)
        else $error("outputs not clear after reset");
    a_conv_cause: assert property (convStart |-> $past(byteWr, 2) && !$past(busy))
        else $error("conversion start without a write");
    a_conv_pulse: assert property (convStart |=> !convStart)
        else $error("conversion start longer than one cycle");
    a_conv_busy: assert property (convStart |-> ##[0:1] busy)
        else $error("no busy after conversion start");
    a_cal_cause: assert property (calStart |-> $past(byteWr, 2) && !convStart)
        else $error("calibration start without a write");
    a_cal_steps: assert property (calStart |=> calSteps inside {3'h7, 3'h3, 3'h1, 3'h2})
        else $error("bad calibration step mask");
    a_target_excl: assert property (testWrEn |-> !calWrEn && !convStart && !calStart)
        else $error("one word reached two targets");
    a_write_cause: assert property ((testWrEn || calWrEn) |-> $past(byteWr, 2))
        else $error("register write without a word");
    a_field_cause: assert property (($changed(bipolarRange) || $changed(calAddr)
        || $changed(powerMode[1:0])) |-> $past(byteWr, 2))
        else $error("control field changed without a write");
    c_conv: cover property (convStart);
    c_cal: cover property (calStart);
    c_test: cover property (testWrEn);
    c_coef: cover property (calWrEn);
endmodule
bind acrs_control_read_select acrs_control_read_select_asserts i_chk (.core_clk(core_clk),
    .resetn(resetn), .byteWr(byteWr), .readData(readData), .testWrEn(testWrEn),
    .calWrEn(calWrEn), .calAddr(calAddr), .convStart(convStart), .calStart(calStart),
    .calSteps(calSteps), .bipolarRange(bipolarRange), .powerMode(powerMode), .busy(busy));
`default_nettype wire

// file: sim/acrs_host_model.sv
// host model: sends each 16-bit word as two byte writes
`timescale 1ns/1ps
`default_nettype none
module acrs_host_model (
    input wire logic core_clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic go, // pulse: send word
    input wire logic [15:0] word, // word to send
    output logic done, // pulse: word sent
    output logic byteWr, // byte strobe
    output logic [7:0] byteIn // byte lines
);
    logic [1:0] phase_q;
    logic [7:0] hi_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 2'h0;
            hi_q <= 8'h00;
            byteWr <= 1'b0;
            byteIn <= 8'h00;
            done <= 1'b0;
        end else begin
            done <= (phase_q == 2'h2);
            byteWr <= (phase_q == 2'h0 && go) || phase_q == 2'h1;
            if (phase_q == 2'h0 && go) begin
                byteIn <= word[7:0];
                hi_q <= word[15:8];
                phase_q <= 2'h1;
            end else if (phase_q == 2'h1) begin
                byteIn <= hi_q;
                phase_q <= 2'h2;
            end else begin
                // idle lines toggle so stale data is never mistaken for a byte
                byteIn <= ~byteIn;
                phase_q <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/tb_adc_control_and_read_select.sv
// self-checking bench for the control word and read-select block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_and_read_select;
    logic core_clk, resetn, go, done, byteWr, sleepPin, convDone, calDone;
    logic testWrEn, calWrEn, convStart, calStart, bipolarRange, busy;
    logic [7:0] byteIn;
    logic [11:0] convResult;
    logic [15:0] word, c, testRdData, calRdData, readData;
    logic [13:0] testWrData, calWrData, testSeen, calSeen;
    logic [1:0] calAddr;
    logic [2:0] calSteps, powerMode;
    logic [31:0] seed = 32'hF7CC4DCB;
    int errCount, checks, convCnt, calCnt, cycles, n;
    acrs_host_model i_acrs_host_model (.core_clk(core_clk), .resetn(resetn), .go(go),
        .word(word), .done(done), .byteWr(byteWr), .byteIn(byteIn));
    acrs_control_read_select i_acrs_control_read_select (.core_clk(core_clk),
        .resetn(resetn), .byteWr(byteWr), .byteIn(byteIn), .sleepPin(sleepPin),
        .convResult(convResult), .convDone(convDone), .calDone(calDone),
        .testRdData(testRdData), .calRdData(calRdData), .readData(readData),
        .testWrData(testWrData), .testWrEn(testWrEn), .calWrData(calWrData),
        .calWrEn(calWrEn), .calAddr(calAddr), .convStart(convStart), .calStart(calStart),
        .calSteps(calSteps), .bipolarRange(bipolarRange), .powerMode(powerMode), .busy(busy));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [15:0] expRead(input logic [15:0] w);
        case (w[7:6])
            2'h0: return {4'h0, convResult};
            2'h1: return testRdData;
            2'h2: return calRdData;
            default: return {6'h00, w[9:8], 2'h3, w[5], 1'b0, w[3:1], 1'b0};
        endcase
    endfunction
    function automatic logic [2:0] steps(input logic [1:0] ch);
        return ch == 2'h0 ? 3'h7 : ch == 2'h1 ? 3'h3 : ch == 2'h2 ? 3'h1 : 3'h2;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // fixed wait covers the two bytes plus the register stages behind them
    task automatic put(input logic [15:0] w);
        word <= w;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic pulse_done(input logic cal);
        convDone <= !cal;
        calDone <= cal;
        @(posedge core_clk);
        convDone <= 1'b0;
        calDone <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (convStart === 1'b1) convCnt++;
        if (calStart === 1'b1) calCnt++;
        if (testWrEn === 1'b1) testSeen = testWrData;
        if (calWrEn === 1'b1) calSeen = calWrData;
        if (cycles == 5000) begin
            errCount++;
            close_out();
        end
    end
    // ==========
    // main sequence
    initial begin
        {resetn, go, word, sleepPin, convDone, calDone} = '0;
        {convResult, testRdData, calRdData} = {12'hABC, 16'h1234, 16'h5678};
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(readData, {4'h0, convResult});
        check({bipolarRange, calAddr, powerMode[1:0], busy}, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            c = {2'h3, 4'h0, seed[1:0], i[1:0], seed[2], 1'b0, seed[5:3], 1'b0};
            sleepPin <= seed[6];
            {convResult, testRdData, calRdData} <= {seed[19:8], seed[31:16], seed[15:0]};
            put(c);
            check(readData, expRead(c));
            check({bipolarRange, calAddr}, {c[5], c[2:1]});
            check(powerMode, {sleepPin, c[9:8]});
            put({2'h1, seed[29:16]});
            check(testSeen, seed[29:16]);
            put({2'h2, seed[13:0]});
            check(calSeen, seed[13:0]);
            put({2'h0, seed[27:14]});
            check(readData, expRead(c));
        end
        n = convCnt;
        put(16'hC0D0);
        put(16'hC0D0);
        check(16'(convCnt - n), 16'h0001);
        check(readData, 16'h00D0);
        pulse_done(1'b0);
        check(readData, 16'h00C0);
        for (int k = 0; k < 8; k++) begin
            n = calCnt;
            put({10'h303, 2'h0, k[2:0], 1'b1});
            check(16'(calCnt - n), 16'h0001);
            check({13'h0000, calSteps}, {13'h0000, steps(k[1:0])});
            check(readData, {10'h003, 1'b0, 1'b1, k[2:0], 1'b1});
            pulse_done(1'b1);
            check(readData, {10'h003, 1'b0, 1'b0, k[2:0], 1'b0});
        end
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(readData, {4'h0, convResult});
        close_out();
    end
endmodule
`default_nettype wire
